// file: rtl/mig_gate.sv
// Top of the interrupt enable gating block: flags, enables and the request pin.
`include "mig_regs.svh"

module mig_gate #(
    parameter int ADDR_W = `MIG_ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [15:0] i_event,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_irq_n
);
    localparam logic [15:0] IMPL = `MIG_IMPL_BITS;
    localparam logic [ADDR_W-1:0] FLAG_ADDR = ADDR_W'(`MIG_FLAG_OFFSET);
    localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'(`MIG_MASK_OFFSET);

    // Nets, because every bit has its own driver inside the generate loop.
    wire mig_pkg::mig_word_t flag_q;
    wire mig_pkg::mig_word_t mask_q;
    logic next_irq_n;

    mig_reg_if bus ();

    mig_reg_port #(
        .ADDR_W(ADDR_W)
    ) u_port (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid),
        .bus(bus.dec)
    );

    // Only the twelve implemented positions get storage, so the reserved
    // field cannot hold a stray one whatever software writes.
    for (genvar b = 0; b < 16; b++) begin : g_bit
        if (IMPL[b]) begin : g_impl
            mig_flag_cell u_cell (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_set(i_event[b]),
                .i_clr(bus.flag_clr[b]),
                .i_en_we(bus.mask_we),
                .i_en_wd(bus.wdata[b]),
                .o_flag(flag_q[b]),
                .o_en(mask_q[b])
            );
        end else begin : g_rsvd
            assign flag_q[b] = 1'b0;
            assign mask_q[b] = 1'b0;
        end
    end

    assign bus.flag = flag_q;
    assign bus.mask = mask_q;

    // The request follows the stored flags and enables, so it stays low until
    // the host clears every enabled flag or disables it.
    always_comb begin
        next_irq_n = ~(|(flag_q & mask_q));
    end

    // Registered so the pin is glitch free; this costs one cycle of latency.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_n <= 1'b1;
        end else begin
            o_irq_n <= next_irq_n;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    logic mask_touched;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_touched <= 1'b0;
        end else if (bus.mask_we) begin
            mask_touched <= 1'b1;
        end
    end

    property p_src(int b);
        (flag_q[b] && mask_q[b]) |=> !o_irq_n;
    endproperty

    AST_DSP_OVERRUN: assert property (p_src(`MIG_BIT_DSP_OVERRUN))
        else $error("DSP overrun with enable did not assert the request");
    AST_DSP_CYCLE_DONE: assert property (p_src(`MIG_BIT_DSP_CYCLE_DONE))
        else $error("DSP cycle done with enable did not assert the request");
    AST_REACTIVE_DIRECTION: assert property (p_src(`MIG_BIT_REACTIVE_DIRECTION))
        else $error("Reactive direction change with enable did not assert the request");
    AST_REAL_DIRECTION: assert property (p_src(`MIG_BIT_REAL_DIRECTION))
        else $error("Real direction change with enable did not assert the request");
    AST_MISSING_ZERO_CROSS: assert property (p_src(`MIG_BIT_MISSING_ZERO_CROSS))
        else $error("Missing zero crossing with enable did not assert the request");
    AST_UNDERVOLTAGE: assert property (p_src(`MIG_BIT_UNDERVOLTAGE))
        else $error("Undervoltage with enable did not assert the request");
    AST_HIGH_VOLTAGE: assert property (p_src(`MIG_BIT_HIGH_VOLTAGE))
        else $error("High voltage with enable did not assert the request");
    AST_HIGH_CURRENT: assert property (p_src(`MIG_BIT_HIGH_CURRENT))
        else $error("Overcurrent with enable did not assert the request");
    AST_CURRENT_VECTOR_SUM: assert property (p_src(`MIG_BIT_CURRENT_VECTOR_SUM))
        else $error("Vector sum threshold with enable did not assert the request");
    AST_ENERGY_OVERFLOW: assert property (p_src(`MIG_BIT_ENERGY_OVERFLOW))
        else $error("Energy overflow with enable did not assert the request");
    AST_CHECKSUM_CHANGE: assert property (p_src(`MIG_BIT_CHECKSUM_CHANGE))
        else $error("Checksum change with enable did not assert the request");
    AST_POWER_FAIL: assert property (p_src(`MIG_BIT_POWER_FAIL))
        else $error("Power fail with enable did not assert the request");

    AST_RESERVED_ZERO: assert property (
        (mask_q[`MIG_RSVD_MSB:`MIG_RSVD_LSB] == 4'h0) && (flag_q[`MIG_RSVD_MSB:`MIG_RSVD_LSB] == 4'h0)
        && (o_reg_rdata[`MIG_RSVD_MSB:`MIG_RSVD_LSB] == 4'h0)
    ) else $error("Reserved enable or flag bits are not zero");

    AST_MASK_RESET: assert property (
        !mask_touched |-> (mask_q == `MIG_MASK_RESET)
    ) else $error("Enable register changed before any write after reset");

    AST_HOLD_UNTIL_CLEAR: assert property (
        (flag_q[`MIG_BIT_POWER_FAIL] && !bus.flag_clr[`MIG_BIT_POWER_FAIL])
        |=> flag_q[`MIG_BIT_POWER_FAIL]
    ) else $error("Flag dropped without a host clear");

    AST_FLAG_SET: assert property (
        (|(i_event & IMPL)) |=> ((flag_q & $past(i_event & IMPL)) == $past(i_event & IMPL))
    ) else $error("Event did not set its flag at the same position");

    AST_SET_BEATS_CLEAR: assert property (
        (i_event[`MIG_BIT_UNDERVOLTAGE] && bus.flag_clr[`MIG_BIT_UNDERVOLTAGE])
        |=> flag_q[`MIG_BIT_UNDERVOLTAGE]
    ) else $error("Clear in the same cycle as an event lost the event");

    AST_IRQ_IDLE_HIGH: assert property (
        !(|(flag_q & mask_q)) |=> o_irq_n
    ) else $error("Request asserted with no enabled flag set");

    AST_IRQ_CLEAR_RELEASE: assert property (
        (!o_irq_n && ((flag_q & ~bus.flag_clr) == 16'h0000) && !(|(i_event & IMPL))) |=> ##1 o_irq_n
    ) else $error("Request did not release after all flags were cleared");

    AST_MASK_WRITE_NEXT: assert property (
        (bus.mask_we && (|(bus.wdata & flag_q)) && !(|bus.flag_clr)) |=> ##1 !o_irq_n
    ) else $error("Enable write did not reach the request two edges later");

    AST_MASK_KEEPS_FLAGS: assert property (
        (bus.mask_we && !(|(i_event & IMPL))) |=> (flag_q == $past(flag_q))
    ) else $error("Enable write altered an event flag");

    AST_MASK_STORE: assert property (
        bus.mask_we |=> (mask_q == $past(bus.wdata))
    ) else $error("Enable register did not store the written value");

    AST_CLEAR_DROPS: assert property (
        (|(bus.flag_clr & ~i_event & IMPL)) |=> ((flag_q & $past(bus.flag_clr & ~i_event & IMPL)) == 16'h0000)
    ) else $error("Host clear did not drop the flag");

    AST_READ_ANSWER: assert property (
        (i_reg_rd && !i_reg_wr) |=> o_reg_rvalid
    ) else $error("Read request got no answer strobe");

    AST_ANSWER_ONLY_ON_READ: assert property (
        !(i_reg_rd && !i_reg_wr) |=> !o_reg_rvalid
    ) else $error("Answer strobe without a read request");

    AST_READ_FLAG: assert property (
        (i_reg_rd && !i_reg_wr && (i_reg_addr == FLAG_ADDR)) |=> (o_reg_rdata == $past(flag_q))
    ) else $error("Flag read-back differs from the stored flags");

    AST_READ_MASK: assert property (
        (i_reg_rd && !i_reg_wr && (i_reg_addr == MASK_ADDR)) |=> (o_reg_rdata == $past(mask_q))
    ) else $error("Enable read-back differs from the stored enables");

    COV_IRQ_RAISE: cover property (
        o_irq_n ##1 !o_irq_n
    );
    COV_IRQ_SERVICED: cover property (
        !o_irq_n ##1 (|bus.flag_clr) ##1 1'b1 ##1 o_irq_n
    );
    COV_SET_AND_CLEAR: cover property (
        |(i_event & bus.flag_clr)
    );
    COV_MASKED_FLAG: cover property (
        ((|flag_q) && o_irq_n) ##1 ((|flag_q) && o_irq_n)
    );
    COV_WRITE_WINS: cover property (
        i_reg_wr && i_reg_rd
    );
endmodule

// file: rtl/mig_regs.svh
// Register offsets, field positions and reset values of the interrupt enable gating block.
`ifndef MIG_REGS_SVH
`define MIG_REGS_SVH

`define MIG_ADDR_W 8
`define MIG_FLAG_OFFSET 8'h04
`define MIG_MASK_OFFSET 8'h06
`define MIG_FLAG_RESET 16'h0000
`define MIG_MASK_RESET 16'h0000
`define MIG_IMPL_BITS 16'hFF0F
`define MIG_RDATA_RESET 16'h0000
`define MIG_RSVD_MSB 7
`define MIG_RSVD_LSB 4

`define MIG_BIT_DSP_OVERRUN 15
`define MIG_BIT_DSP_CYCLE_DONE 14
`define MIG_BIT_REACTIVE_DIRECTION 13
`define MIG_BIT_REAL_DIRECTION 12
`define MIG_BIT_MISSING_ZERO_CROSS 11
`define MIG_BIT_UNDERVOLTAGE 10
`define MIG_BIT_HIGH_VOLTAGE 9
`define MIG_BIT_HIGH_CURRENT 8
`define MIG_BIT_CURRENT_VECTOR_SUM 3
`define MIG_BIT_ENERGY_OVERFLOW 2
`define MIG_BIT_CHECKSUM_CHANGE 1
`define MIG_BIT_POWER_FAIL 0

`endif

// file: rtl/mig_pkg.sv
// Types shared by the interrupt enable gating block.
package mig_pkg;
    typedef logic [15:0] mig_word_t;
    typedef enum logic [1:0] {
        MIG_ACC_NONE = 2'b00,
        MIG_ACC_READ = 2'b01,
        MIG_ACC_WRITE = 2'b11
    } mig_acc_e;
endpackage

// file: rtl/mig_reg_if.sv
// Carrier between the register port decoder and the flag and enable core.
interface mig_reg_if;
    logic mask_we;
    mig_pkg::mig_word_t wdata;
    mig_pkg::mig_word_t flag_clr;
    mig_pkg::mig_word_t flag;
    mig_pkg::mig_word_t mask;

    modport dec (
        output mask_we,
        output wdata,
        output flag_clr,
        input flag,
        input mask
    );
    modport core (
        input mask_we,
        input wdata,
        input flag_clr,
        output flag,
        output mask
    );
endinterface

// file: rtl/mig_flag_cell.sv
// One event flag with its interrupt enable bit.
module mig_flag_cell (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_set,
    input wire logic i_clr,
    input wire logic i_en_we,
    input wire logic i_en_wd,
    output logic o_flag,
    output logic o_en
);
    // An event in the same cycle as a host clear keeps the flag set.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_en <= 1'b0;
        end else if (i_en_we) begin
            o_en <= i_en_wd;
        end
    end
endmodule

// file: rtl/mig_reg_port.sv
// Register port decoder: write strobes and registered read-back.
`include "mig_regs.svh"

module mig_reg_port #(
    parameter int ADDR_W = `MIG_ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    mig_reg_if.dec bus
);
    localparam logic [ADDR_W-1:0] FLAG_ADDR = ADDR_W'(`MIG_FLAG_OFFSET);
    localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'(`MIG_MASK_OFFSET);
    localparam logic [15:0] IMPL = `MIG_IMPL_BITS;

    mig_pkg::mig_acc_e acc;

    // A write and a read in the same cycle count as a write.
    always_comb begin
        if (i_reg_wr) begin
            acc = mig_pkg::MIG_ACC_WRITE;
        end else if (i_reg_rd) begin
            acc = mig_pkg::MIG_ACC_READ;
        end else begin
            acc = mig_pkg::MIG_ACC_NONE;
        end
    end

    always_comb begin
        bus.wdata = i_reg_wdata & IMPL;
        bus.mask_we = (acc == mig_pkg::MIG_ACC_WRITE) && (i_reg_addr == MASK_ADDR);
        if ((acc == mig_pkg::MIG_ACC_WRITE) && (i_reg_addr == FLAG_ADDR)) begin
            bus.flag_clr = i_reg_wdata & IMPL;
        end else begin
            bus.flag_clr = `MIG_FLAG_RESET;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= (acc == mig_pkg::MIG_ACC_READ);
        end
    end

    // Unmapped addresses read as zero; reads have no side effect.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= `MIG_RDATA_RESET;
        end else if (acc != mig_pkg::MIG_ACC_READ) begin
            o_reg_rdata <= `MIG_RDATA_RESET;
        end else if (i_reg_addr == FLAG_ADDR) begin
            o_reg_rdata <= bus.flag;
        end else if (i_reg_addr == MASK_ADDR) begin
            o_reg_rdata <= bus.mask;
        end else begin
            o_reg_rdata <= `MIG_RDATA_RESET;
        end
    end
endmodule

// file: verification/mig_host_model.sv
// Host model that drives the register port and services interrupt requests.
`include "mig_regs.svh"

module mig_host_model (
    input wire logic i_ref_clk,
    input wire logic [15:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [`MIG_ADDR_W-1:0] o_reg_addr,
    output logic [15:0] o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_ref_clk);
        // Released lines show inverted values so that stale data never passes for a live request.
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_ref_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        // The answer stands for one cycle and is taken at the edge that samples it high.
        @(posedge i_ref_clk);
        d = i_reg_rdata;
        v = i_reg_rvalid;
    endtask

    // Write and read in one cycle; the write wins, so no answer strobe may follow.
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic v);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
        @(posedge i_ref_clk);
        v = i_reg_rvalid;
    endtask

    // Service may be prompt or slow; the flags read are written back as ones to clear them.
    task automatic service(input int delay, output logic [15:0] f);
        logic v;
        repeat (delay) @(posedge i_ref_clk);
        rd(`MIG_FLAG_OFFSET, f, v);
        wr(`MIG_FLAG_OFFSET, f);
    endtask
endmodule

// file: verification/mig_gate_tb.sv
// Self-checking testbench of the interrupt enable gating block.
`include "mig_regs.svh"

module mig_gate_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] ev = 16'h0000;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic irq_n;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] rng = 32'h0000_0018;

    always #50 clk = ~clk;

    mig_gate #(.ADDR_W(`MIG_ADDR_W)) dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_event(ev), .o_reg_rdata(reg_rdata),
        .o_reg_rvalid(reg_rvalid), .o_irq_n(irq_n));
    mig_host_model host (.i_ref_clk(clk), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic exp_irq_n(input logic [15:0] f, input logic [15:0] m);
        return ~|(f & m & `MIG_IMPL_BITS);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic settle;
        @(posedge clk);
        @(negedge clk);
    endtask

    // Event to pin takes two edges, so the check lands after both.
    task automatic pulse(input logic [15:0] x);
        @(posedge clk);
        ev <= x;
        @(posedge clk);
        ev <= 16'h0000;
        settle();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        logic [15:0] d, f, m, fl;
        logic v;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host.rd(`MIG_MASK_OFFSET, d, v);
        check({15'h0000, v}, 16'h0001, "read strobe");
        check(d, 16'h0000, "enable reset");
        host.rd(`MIG_FLAG_OFFSET, d, v);
        check(d, 16'h0000, "flag reset");
        check({15'h0000, irq_n}, 16'h0001, "request after reset");
        host.rd(8'h10, d, v);
        check(d, 16'h0000, "unmapped read");
        for (int b = 0; b < 16; b++) begin
            m = 16'h0001 << b;
            host.wr(`MIG_MASK_OFFSET, ~m);
            pulse(m);
            check({15'h0000, irq_n}, 16'h0001, "other enable");
            host.wr(`MIG_MASK_OFFSET, m);
            settle();
            check({15'h0000, irq_n}, {15'h0000, exp_irq_n(m, m)}, "own enable");
            host.rd(`MIG_FLAG_OFFSET, d, v);
            check(d, m & `MIG_IMPL_BITS, "flag position");
            host.service(b % 3, f);
            settle();
            check({15'h0000, irq_n}, 16'h0001, "request after clear");
        end
        fl = 16'h0000;
        repeat (40) begin
            rng = xorshift(rng);
            m = rng[15:0];
            host.wr(`MIG_MASK_OFFSET, m);
            host.rd(`MIG_MASK_OFFSET, d, v);
            check(d, m & `MIG_IMPL_BITS, "enable readback");
            pulse(rng[31:16] & rng[23:8]);
            fl |= rng[31:16] & rng[23:8] & `MIG_IMPL_BITS;
            check({15'h0000, irq_n}, {15'h0000, exp_irq_n(fl, m)}, "random gating");
            if (rng[0]) begin
                host.service(int'(rng[2:1]), f);
                check(f, fl, "flag image");
                fl = 16'h0000;
                settle();
                check({15'h0000, irq_n}, 16'h0001, "serviced");
            end
        end
        host.service(0, f);
        check(f, fl, "flag image before corners");
        host.wr_rd(`MIG_MASK_OFFSET, 16'h0400, v);
        check({15'h0000, v}, 16'h0000, "write beats read");
        host.rd(`MIG_MASK_OFFSET, d, v);
        check(d, 16'h0400, "write beats read data");
        // An event that meets the host clear in one cycle must survive it.
        @(posedge clk);
        ev <= 16'h0400;
        host.wr(`MIG_FLAG_OFFSET, 16'h0400);
        ev <= 16'h0000;
        settle();
        check({15'h0000, irq_n}, 16'h0000, "set beats clear");
        host.rd(`MIG_FLAG_OFFSET, d, v);
        check(d, 16'h0400, "set beats clear flag");
        // Reset in mid-run while an enable and a flag are set.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        check({15'h0000, irq_n}, 16'h0001, "request after mid-run reset");
        host.rd(`MIG_MASK_OFFSET, d, v);
        check(d, 16'h0000, "enable after mid-run reset");
        host.rd(`MIG_FLAG_OFFSET, d, v);
        check(d, 16'h0000, "flag after mid-run reset");
        complete_run();
    end
endmodule
